/* core/can_rx_fifo.sv */
// Receive background buffer, five entry FIFO and foreground window
module can_rx_fifo (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Protocol engine side
	input wire can_rx_pkg::bg_wr_t bg_wr,
	input wire can_rx_pkg::frame_evt_t frame,
	input wire logic tx_active,
	input wire logic arb_lost,
	input wire logic loopback,
	output logic ack_allow,
	output logic rx_event,
	output logic overrun_event,
	// Configuration
	input wire logic init_request,
	output logic init_acknowledge,
	input wire logic cfg_wr_en,
	input wire logic [can_rx_pkg::SEL_W-1:0] cfg_wr_sel,
	input wire logic [7:0] cfg_wr_data,
	// CPU foreground window
	input wire logic [can_rx_pkg::IDX_W-1:0] fg_rd_addr,
	input wire logic rx_flag_clear,
	output logic [7:0] fg_rd_data,
	output logic rx_full_flag,
	output logic [can_rx_pkg::HIT_W-1:0] filter_hit_index
);

	localparam logic [2:0] DEPTH = 3'(can_rx_pkg::RX_DEPTH);

	can_rx_pkg::rx_state_t state_q, state_d;
	logic init_ack_q;
	logic own_q;
	logic ack_allow_q;
	logic rx_event_q;
	logic overrun_q;
	logic flag_q;
	logic [2:0] hit_q;
	logic [7:0] rd_data_q;
	logic [2:0] cnt_q, cnt_d;
	logic [2:0] wr_ptr_q, rd_ptr_q;
	can_rx_pkg::filt_mode_t mode_q;
	can_rx_pkg::bank_t value_q, mask_q;
	logic [7:0] bg_q [can_rx_pkg::BUF_BYTES];
	logic [7:0] mem_q [can_rx_pkg::RX_DEPTH][can_rx_pkg::BUF_BYTES];
	logic [2:0] mem_hit_q [can_rx_pkg::RX_DEPTH];
	can_rx_pkg::ident_t ident;
	logic [can_rx_pkg::FILTERS-1:0] f_match;
	logic f_accept;
	logic [2:0] f_hit;
	logic eligible, accepted, full, push, pop, cfg_ok;

	function automatic logic [2:0] ptr_next(input logic [2:0] p);
		ptr_next = (p == DEPTH - 3'h1) ? 3'h0 : p + 3'h1;
	endfunction

	// ****************************************
	// Initialization handshake and frame tracking
	// ****************************************
	// Init is only entered between frames so a frame in flight is not torn
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			can_rx_pkg::ST_INIT: begin
				if (!init_request) begin
					state_d = can_rx_pkg::ST_IDLE;
				end
			end
			can_rx_pkg::ST_IDLE: begin
				if (init_request) begin
					state_d = can_rx_pkg::ST_INIT;
				end else if (frame.start) begin
					state_d = can_rx_pkg::ST_FRAME;
				end
			end
			can_rx_pkg::ST_FRAME: begin
				if (frame.done) begin
					state_d = init_request ? can_rx_pkg::ST_INIT : can_rx_pkg::ST_IDLE;
				end
			end
			default: state_d = can_rx_pkg::ST_INIT;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= can_rx_pkg::ST_INIT;
			init_ack_q <= 1'b1;
		end else begin
			state_q <= state_d;
			init_ack_q <= (state_d == can_rx_pkg::ST_INIT);
		end
	end

	// Own frame marker; losing arbitration turns the node into a receiver
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			own_q <= 1'b0;
		end else if (arb_lost) begin
			own_q <= 1'b0;
		end else if (state_q == can_rx_pkg::ST_IDLE && frame.start) begin
			own_q <= tx_active;
		end
	end

	// Registered so the output comes from a flop; it trails the own marker by one cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_allow_q <= 1'b0;
		end else begin
			ack_allow_q <= !own_q || loopback;
		end
	end

	// ****************************************
	// Filter configuration
	// ****************************************
	assign cfg_ok = cfg_wr_en && init_ack_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_q <= can_rx_pkg::MODE_RST;
			value_q <= {can_rx_pkg::BANK_BYTES{can_rx_pkg::VALUE_RST}};
			mask_q <= {can_rx_pkg::BANK_BYTES{can_rx_pkg::MASK_RST}};
		end else if (cfg_ok) begin
			if (cfg_wr_sel == can_rx_pkg::SEL_MODE) begin
				mode_q <= can_rx_pkg::filt_mode_t'(cfg_wr_data[1:0]);
			end else if (cfg_wr_sel < can_rx_pkg::SEL_MASK_BASE) begin
				value_q[cfg_wr_sel[2:0]] <= cfg_wr_data;
			end else if (cfg_wr_sel < can_rx_pkg::SEL_MODE) begin
				mask_q[cfg_wr_sel[2:0]] <= cfg_wr_data;
			end
		end
	end

	// ****************************************
	// Background buffer
	// ****************************************
	// Kept apart from the FIFO so a new frame can land while software still reads
	always_ff @(posedge core_clk) begin
		if (bg_wr.en && state_q == can_rx_pkg::ST_FRAME && bg_wr.idx < 4'(can_rx_pkg::BUF_BYTES)) begin
			bg_q[bg_wr.idx] <= bg_wr.data;
		end
	end

	generate
		for (genvar i = 0; i < can_rx_pkg::ID_BYTES; i++) begin : g_id
			assign ident[i] = bg_q[i];
		end
	endgenerate

	can_rx_accept_filter i_can_rx_accept_filter (
		.mode(mode_q),
		.value(value_q),
		.mask(mask_q),
		.ident(ident),
		.match(f_match),
		.accept(f_accept),
		.hit_idx(f_hit)
	);

	// ****************************************
	// Push decision
	// ****************************************
	// Decision uses the count before any same cycle clear, so a full FIFO still drops
	assign eligible = frame.done && frame.ok && state_q == can_rx_pkg::ST_FRAME
		&& (!own_q || loopback);
	assign accepted = eligible && f_accept;
	assign full = (cnt_q == DEPTH);
	assign push = accepted && !full;
	assign pop = rx_flag_clear && cnt_q != 3'h0;

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 3'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 3'h1;
		end
	end

	// ****************************************
	// FIFO pointers and storage
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 3'h0;
			wr_ptr_q <= 3'h0;
			rd_ptr_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
			if (push) begin
				wr_ptr_q <= ptr_next(wr_ptr_q);
			end
			if (pop) begin
				rd_ptr_q <= ptr_next(rd_ptr_q);
			end
		end
	end

	// Storage has no reset; only entries below the count are ever read
	always_ff @(posedge core_clk) begin
		if (push) begin
			for (int b = 0; b < can_rx_pkg::BUF_BYTES; b++) begin
				mem_q[wr_ptr_q][b] <= bg_q[b];
			end
			mem_hit_q[wr_ptr_q] <= f_hit;
		end
	end

	// ****************************************
	// Foreground window and events
	// ****************************************
	// Same cycle push and clear leave the count, so the set is never lost
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
			hit_q <= can_rx_pkg::HIT_RST;
			rd_data_q <= 8'h00;
		end else begin
			flag_q <= (cnt_q != 3'h0);
			hit_q <= (cnt_q != 3'h0) ? mem_hit_q[rd_ptr_q] : can_rx_pkg::HIT_RST;
			if (cnt_q != 3'h0 && fg_rd_addr < 4'(can_rx_pkg::BUF_BYTES)) begin
				rd_data_q <= mem_q[rd_ptr_q][fg_rd_addr];
			end else begin
				rd_data_q <= 8'h00;
			end
		end
	end

	// One cycle pulses; masking belongs to the interrupt logic outside this block
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_event_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			rx_event_q <= push;
			overrun_q <= accepted && full;
		end
	end

	assign init_acknowledge = init_ack_q;
	assign ack_allow = ack_allow_q;
	assign rx_event = rx_event_q;
	assign overrun_event = overrun_q;
	assign rx_full_flag = flag_q;
	assign filter_hit_index = hit_q;
	assign fg_rd_data = rd_data_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_depth_bound;
		cnt_q <= DEPTH;
	endproperty
	a_depth_bound: assert property (p_depth_bound) else $error("FIFO count above depth");

	property p_flag_tracks;
		##1 (flag_q == ($past(cnt_q) != 3'h0));
	endproperty
	a_flag_tracks: assert property (p_flag_tracks) else $error("full flag does not track FIFO");

	property p_push_flag;
		push |=> ##1 flag_q && rx_event_q == 1'b0 || flag_q;
	endproperty
	a_push_flag: assert property (p_push_flag) else $error("push did not set full flag");

	property p_push_event;
		push |=> rx_event_q && cnt_q == $past(cnt_q) + 3'(!$past(pop));
	endproperty
	a_push_event: assert property (p_push_event) else $error("push not counted or signalled");

	property p_bad_frame;
		frame.done && !frame.ok |=> !rx_event_q && cnt_q <= $past(cnt_q);
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("invalid frame was stored");

	property p_own_frame;
		frame.done && own_q && !loopback |=> !rx_event_q && !overrun_q;
	endproperty
	a_own_frame: assert property (p_own_frame) else $error("own frame stored without loopback");

	property p_overrun;
		accepted && cnt_q == DEPTH && !pop |=> overrun_q && cnt_q == DEPTH && !rx_event_q;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged or frame kept");

	property p_hit_lowest;
		accepted |-> f_match[f_hit] && ((f_match & ((8'h01 << f_hit) - 8'h01)) == 8'h00);
	endproperty
	a_hit_lowest: assert property (p_hit_lowest) else $error("hit index not lowest match");

	property p_closed;
		mode_q == can_rx_pkg::FILT_CLOSED |-> !f_accept;
	endproperty
	a_closed: assert property (p_closed) else $error("closed filter accepted a frame");

	property p_cfg_lock;
		cfg_wr_en && !init_ack_q |=> $stable(value_q) && $stable(mask_q) && $stable(mode_q);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("configuration changed outside init");

	property p_order;
		pop |=> rd_ptr_q == ptr_next($past(rd_ptr_q));
	endproperty
	a_order: assert property (p_order) else $error("read pointer skipped an entry");

	c_push: cover property (push);
	c_overrun: cover property (accepted && full);
	c_push_pop: cover property (push && pop && cnt_q == 3'h1);
	c_loopback: cover property (push && own_q && loopback);

endmodule

/* core/can_rx_pkg.sv */
// Shared constants and types for the CAN receive FIFO and acceptance filter
package can_rx_pkg;

	// ****************************************
	// Storage geometry
	// ****************************************
	localparam int RX_DEPTH = 5;
	localparam int BUF_BYTES = 15;
	localparam int ID_BYTES = 4;
	localparam int BANK_BYTES = 8;
	localparam int FILTERS = 8;
	localparam int HIT_W = 3;
	localparam int PTR_W = 3;
	localparam int CNT_W = 3;
	localparam int IDX_W = 4;

	// ****************************************
	// Configuration write selects
	// ****************************************
	localparam int SEL_W = 5;
	localparam logic [4:0] SEL_VALUE_BASE = 5'h00;
	localparam logic [4:0] SEL_MASK_BASE = 5'h08;
	localparam logic [4:0] SEL_MODE = 5'h10;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] VALUE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [2:0] HIT_RST = 3'h0;

	typedef enum logic [1:0] {
		FILT_32 = 2'h0,
		FILT_16 = 2'h1,
		FILT_8 = 2'h2,
		FILT_CLOSED = 2'h3
	} filt_mode_t;

	localparam filt_mode_t MODE_RST = FILT_32;

	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_IDLE = 3'b010,
		ST_FRAME = 3'b100
	} rx_state_t;

	// Byte written by the protocol engine into the background buffer
	typedef struct packed {
		logic en;
		logic [3:0] idx;
		logic [7:0] data;
	} bg_wr_t;

	// Frame boundary events from the protocol engine
	typedef struct packed {
		logic start;
		logic done;
		logic ok;
	} frame_evt_t;

	typedef logic [BANK_BYTES-1:0][7:0] bank_t;
	typedef logic [ID_BYTES-1:0][7:0] ident_t;

endpackage

/* core/can_rx_accept_filter.sv */
// Identifier acceptance filter: 32, 16 and 8 bit split and closed mode
module can_rx_accept_filter (
	// Configuration
	input wire can_rx_pkg::filt_mode_t mode,
	input wire can_rx_pkg::bank_t value,
	input wire can_rx_pkg::bank_t mask,
	// Identifier bytes of the frame
	input wire can_rx_pkg::ident_t ident,
	// Result
	output logic [can_rx_pkg::FILTERS-1:0] match,
	output logic accept,
	output logic [can_rx_pkg::HIT_W-1:0] hit_idx
);

	logic [can_rx_pkg::BANK_BYTES-1:0] byte_ok;

	// ****************************************
	// Per byte compare, mask bit 1 ignores the bit
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < can_rx_pkg::BANK_BYTES; g++) begin : g_byte
			logic [7:0] sel;
			always_comb begin
				unique case (mode)
					can_rx_pkg::FILT_32: sel = ident[g % 4];
					can_rx_pkg::FILT_16: sel = ident[g % 2];
					default: sel = ident[0];
				endcase
			end
			assign byte_ok[g] = ~|((sel ^ value[g]) & ~mask[g]);
		end
	endgenerate

	always_comb begin
		match = '0;
		unique case (mode)
			can_rx_pkg::FILT_32: begin
				match[0] = &byte_ok[3:0];
				match[1] = &byte_ok[7:4];
			end
			can_rx_pkg::FILT_16: begin
				for (int f = 0; f < 4; f++) begin
					match[f] = &byte_ok[2*f +: 2];
				end
			end
			can_rx_pkg::FILT_8: match = byte_ok;
			can_rx_pkg::FILT_CLOSED: match = '0;
		endcase
	end

	// Lowest numbered matching filter is reported
	always_comb begin
		hit_idx = '0;
		for (int f = can_rx_pkg::FILTERS - 1; f >= 0; f--) begin
			if (match[f]) begin
				hit_idx = 3'(f);
			end
		end
	end

	assign accept = |match;

endmodule

/* bench/can_engine_model.sv */
// Protocol engine model that hands whole frames to the receive block
module can_engine_model (
	// Clock
	input wire logic core_clk,
	// Frame delivery
	output can_rx_pkg::bg_wr_t bg_wr,
	output can_rx_pkg::frame_evt_t frame,
	output logic tx_active,
	output logic arb_lost
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		bg_wr = '0;
		frame = '0;
		tx_active = 1'b0;
		arb_lost = 1'b0;
	end

	// ****************************************
	// Frame delivery
	// ****************************************
	// Idle data shows the inverse of the last byte, except at the end of a slow frame, where it repeats the last byte
	task automatic send(input can_rx_pkg::ident_t id, input logic ok, input logic own, input logic lose,
			input logic slow);
		@(posedge core_clk);
		frame.start <= 1'b1;
		tx_active <= own;
		for (int i = 0; i < can_rx_pkg::BUF_BYTES; i++) begin
			@(posedge core_clk);
			frame.start <= 1'b0;
			arb_lost <= lose && (i == 2);
			bg_wr <= '{en: 1'b1, idx: 4'(i), data: (i < 4) ? id[i] : id[0] ^ 8'(i)};
			if (slow) begin
				@(posedge core_clk);
				arb_lost <= 1'b0;
				bg_wr <= '{en: 1'b0, idx: 4'hf, data: ~bg_wr.data};
			end
		end
		@(posedge core_clk);
		arb_lost <= 1'b0;
		bg_wr <= '{en: 1'b0, idx: 4'hf, data: ~bg_wr.data};
		frame.done <= 1'b1;
		frame.ok <= ok;
		@(posedge core_clk);
		frame.done <= 1'b0;
		frame.ok <= ~ok;
		tx_active <= 1'b0;
	endtask
endmodule

/* bench/tb_can_rx_fifo.sv */
// Self-checking bench for the receive FIFO and acceptance filter
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
	$display("wrong value %s expected %h seen %h", name, exp, got); end end
module tb_can_rx_fifo;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [31:0] id;
		logic [2:0] hit;
	} exp_entry_t;

	logic core_clk, rst, tx_active, arb_lost, loopback, ack_allow, rx_event, overrun_event;
	logic init_request, init_acknowledge, cfg_wr_en, rx_flag_clear, rx_full_flag, ack_hi, slow;
	can_rx_pkg::bg_wr_t bg_wr;
	can_rx_pkg::frame_evt_t frame;
	logic [can_rx_pkg::SEL_W-1:0] cfg_wr_sel;
	logic [7:0] cfg_wr_data, fg_rd_data;
	logic [can_rx_pkg::IDX_W-1:0] fg_rd_addr;
	logic [can_rx_pkg::HIT_W-1:0] filter_hit_index;
	int fails, checked, n_rx, n_ovr, cyc, n0;
	exp_entry_t q[$];

	can_rx_fifo i_can_rx_fifo (.core_clk, .rst, .bg_wr, .frame, .tx_active, .arb_lost, .loopback, .ack_allow,
		.rx_event, .overrun_event, .init_request, .init_acknowledge, .cfg_wr_en, .cfg_wr_sel, .cfg_wr_data,
		.fg_rd_addr, .rx_flag_clear, .fg_rd_data, .rx_full_flag, .filter_hit_index);
	can_engine_model i_can_engine_model (.core_clk, .bg_wr, .frame, .tx_active, .arb_lost);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// ****************************************
	// Event monitor and timeout
	// ****************************************
	always @(posedge core_clk) begin
		cyc++;
		if (rx_event === 1'b1) n_rx++;
		if (overrun_event === 1'b1) n_ovr++;
		// The acknowledge slot sits at frame end; ack_allow trails the own marker one cycle
		if (frame.done === 1'b1 && ack_allow === 1'b1) ack_hi = 1'b1;
		if (cyc == 20000) begin
			fails++;
			$display("timeout after %0d cycles", cyc);
			end_sim();
		end
	end

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic wait_init(input logic lvl);
		int n;
		n = 0;
		while (init_acknowledge !== lvl && n < 20) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		`CHK("init_acknowledge", lvl, init_acknowledge)
	endtask

	task automatic cfg(input can_rx_pkg::filt_mode_t m, input can_rx_pkg::bank_t v, input can_rx_pkg::bank_t k);
		@(posedge core_clk);
		init_request <= 1'b1;
		wait_init(1'b1);
		for (int i = 0; i < 17; i++) begin
			@(posedge core_clk);
			cfg_wr_en <= 1'b1;
			cfg_wr_sel <= 5'(i);
			cfg_wr_data <= (i < 8) ? v[i] : (i < 16) ? k[i - 8] : 8'(m);
		end
		@(posedge core_clk);
		cfg_wr_en <= 1'b0;
		init_request <= 1'b0;
		wait_init(1'b0);
		@(posedge core_clk);
	endtask

	task automatic rx(input logic [31:0] id, input logic ok, own, lose, input int exp, input logic [2:0] hit);
		int r0;
		int o0;
		r0 = n_rx;
		o0 = n_ovr;
		ack_hi = 1'b0;
		i_can_engine_model.send(id, ok, own, lose, slow);
		repeat (4) @(posedge core_clk);
		#1;
		`CHK("rx_event count", r0 + (exp == 1), n_rx)
		`CHK("overrun_event count", o0 + (exp == 2), n_ovr)
		if (exp == 1) q.push_back('{id: id, hit: hit});
		`CHK("rx_full_flag", q.size() != 0, rx_full_flag)
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		fg_rd_addr <= a;
		@(posedge core_clk);
		#1;
		`CHK("fg_rd_data", e, fg_rd_data)
	endtask

	task automatic pop();
		exp_entry_t e;
		e = q.pop_front();
		`CHK("filter_hit_index", e.hit, filter_hit_index)
		rd(4'h0, e.id[7:0]);
		rd(4'h3, e.id[31:24]);
		rd(4'he, e.id[7:0] ^ 8'h0e);
		rd(4'hf, 8'h00);
		@(posedge core_clk);
		rx_flag_clear <= 1'b1;
		@(posedge core_clk);
		rx_flag_clear <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		`CHK("rx_full_flag after clear", q.size() != 0, rx_full_flag)
	endtask

	task automatic drain();
		while (q.size() != 0) pop();
		`CHK("filter_hit_index empty", 3'h0, filter_hit_index)
	endtask

	task automatic end_sim();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		loopback = 1'b0;
		init_request = 1'b1;
		cfg_wr_en = 1'b0;
		cfg_wr_sel = '0;
		cfg_wr_data = 8'h00;
		fg_rd_addr = 4'h0;
		rx_flag_clear = 1'b0;
		slow = 1'b0;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK("init_acknowledge reset", 1'b1, init_acknowledge)
		`CHK("rx_full_flag reset", 1'b0, rx_full_flag)
		`CHK("filter_hit_index reset", can_rx_pkg::HIT_RST, filter_hit_index)
		$display("test reset done");
		// Bank 1 only looks at byte 0, so it overlaps bank 0 on purpose
		cfg(can_rx_pkg::FILT_32, 64'h00000011_44332211, 64'hffffff00_00000000);
		rx(32'h44332211, 1'b1, 1'b0, 1'b0, 1, 3'h0);
		rx(32'hccbbaa11, 1'b1, 1'b0, 1'b0, 1, 3'h1);
		rx(32'h44332212, 1'b1, 1'b0, 1'b0, 0, 3'h0);
		rx(32'h44332211, 1'b0, 1'b0, 1'b0, 0, 3'h0);
		rx(32'h44332211, 1'b1, 1'b1, 1'b0, 0, 3'h0);
		`CHK("ack_allow own frame", 1'b0, ack_hi)
		rx(32'h44332211, 1'b1, 1'b1, 1'b1, 1, 3'h0);
		@(posedge core_clk);
		loopback <= 1'b1;
		rx(32'h44332211, 1'b1, 1'b1, 1'b0, 1, 3'h0);
		`CHK("ack_allow loopback", 1'b1, ack_hi)
		@(posedge core_clk);
		loopback <= 1'b0;
		cfg_wr_en <= 1'b1;
		cfg_wr_sel <= can_rx_pkg::SEL_VALUE_BASE;
		@(posedge core_clk);
		cfg_wr_en <= 1'b0;
		slow = 1'b1;
		rx(32'h44332211, 1'b1, 1'b0, 1'b0, 1, 3'h0);
		slow = 1'b0;
		rx(32'h00000011, 1'b1, 1'b0, 1'b0, 2, 3'h0);
		pop();
		rx(32'h77665511, 1'b1, 1'b0, 1'b0, 1, 3'h1);
		drain();
		$display("test 32 bit done");
		cfg(can_rx_pkg::FILT_16, 64'h2210_2211_ffff_2210, 64'h0001_0000_0000_0000);
		rx(32'h99882211, 1'b1, 1'b0, 1'b0, 1, 3'h2);
		rx(32'h00002213, 1'b1, 1'b0, 1'b0, 0, 3'h0);
		n0 = n_rx;
		i_can_engine_model.send(32'h00002210, 1'b1, 1'b0, 1'b0, 1'b0);
		i_can_engine_model.send(32'h1234ffff, 1'b1, 1'b0, 1'b0, 1'b0);
		q.push_back('{id: 32'h00002210, hit: 3'h0});
		q.push_back('{id: 32'h1234ffff, hit: 3'h1});
		repeat (4) @(posedge core_clk);
		#1;
		`CHK("rx_event back to back", n0 + 2, n_rx)
		drain();
		$display("test 16 bit done");
		cfg(can_rx_pkg::FILT_8, 64'h17161514_13121110, 64'h0);
		for (int k = 0; k < 8; k++) begin
			rx({8'(k), 8'(k), 8'(k), 8'h10 + 8'(k)}, 1'b1, 1'b0, 1'b0, 1, 3'(k));
			pop();
		end
		$display("test 8 bit done");
		cfg(can_rx_pkg::FILT_CLOSED, 64'h17161514_13121110, 64'hffffffff_ffffffff);
		rx(32'h00000010, 1'b1, 1'b0, 1'b0, 0, 3'h0);
		$display("test closed done");
		end_sim();
	end
endmodule
